/* design/gpt_pkg.sv */
// Shared constants for the joined 32-bit timer block.
`default_nettype none
package gpt_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_WIDTH_CFG   = 8'h00;
    localparam logic [7:0] OFS_LOWER_MODE  = 8'h04;
    localparam logic [7:0] OFS_UPPER_MODE  = 8'h08;
    localparam logic [7:0] OFS_CONTROL     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
    localparam logic [7:0] OFS_RAW_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_MASKED_STAT = 8'h20;
    localparam logic [7:0] OFS_STAT_CLEAR  = 8'h24;
    localparam logic [7:0] OFS_LOWER_LOAD  = 8'h28;
    localparam logic [7:0] OFS_UPPER_LOAD  = 8'h2c;
    localparam logic [7:0] OFS_LOWER_MATCH = 8'h30;
    localparam logic [7:0] OFS_UPPER_MATCH = 8'h34;
    localparam logic [7:0] OFS_LOWER_PRESC = 8'h38;
    localparam logic [7:0] OFS_UPPER_PRESC = 8'h3c;
    localparam logic [7:0] OFS_LOWER_COUNT = 8'h48;
    localparam logic [7:0] OFS_UPPER_COUNT = 8'h4c;
    // Width configuration values.
    localparam logic [2:0] CFG_TIMER32 = 3'h0;
    localparam logic [2:0] CFG_CLOCK32 = 3'h1;
    // Lower half mode field values.
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    // Control register bit positions.
    localparam int CTL_LOWER_EN    = 0;
    localparam int CTL_LOWER_STALL = 1;
    localparam int CTL_CLOCK_EN    = 4;
    localparam int CTL_LOWER_TRIG  = 5;
    localparam int CTL_UPPER_EN    = 8;
    localparam int CTL_UPPER_STALL = 9;
    localparam int CTL_UPPER_TRIG  = 13;
    // Status, mask and clear bit positions.
    localparam int ST_LOWER_TIMEOUT = 0;
    localparam int ST_CLOCK_MATCH   = 3;
    // Reset values, and the count loaded on entering clock mode.
    localparam logic [15:0] RST_HALF_COUNT = 16'hffff;
    localparam logic [15:0] RST_HALF_LOAD  = 16'hffff;
    localparam logic [7:0]  RST_PRESCALE   = 8'h00;
    localparam logic [31:0] CLOCK_FIRST    = 32'h0000_0001;
    // Timing: the pin clock rate and the tick rate it is divided to.
    localparam int CLOCK_IN_HZ = 32768;
    localparam int TICK_HZ     = 1;
    localparam int CLOCK_DIV   = CLOCK_IN_HZ / TICK_HZ;
endpackage : gpt_pkg
`default_nettype wire

/* design/gpt_tick_div.sv */
// Pin clock synchroniser, edge detector and divider to a one second tick.
`default_nettype none
module gpt_tick_div
    import gpt_pkg::*;
#(
    parameter int DIV = CLOCK_DIV
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_clk,
    input  wire logic run,
    output logic      tick
);
    logic        sync_a;
    logic        sync_b;
    logic        sync_c;
    logic [15:0] edge_cnt;

    // Two flops bring the slow pin clock into the core domain; the third
    // holds the previous level for edge detection.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end
        else
        begin
            sync_a <= pin_clk;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // The divider restarts whenever the clock mode is not running, so the
    // first tick comes on the DIV-th rising pin edge seen after enable.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            edge_cnt <= 16'h0000;
            tick     <= 1'b0;
        end
        else if (!run)
        begin
            edge_cnt <= 16'h0000;
            tick     <= 1'b0;
        end
        else if (sync_b && !sync_c)
        begin
            if (edge_cnt == 16'(DIV - 1))
            begin
                edge_cnt <= 16'h0000;
                tick     <= 1'b1;
            end
            else
            begin
                edge_cnt <= edge_cnt + 16'h0001;
                tick     <= 1'b0;
            end
        end
        else
        begin
            tick <= 1'b0;
        end
    end
endmodule : gpt_tick_div
`default_nettype wire

/* design/gpt_timer.sv */
// Two 16-bit halves joined as a 32-bit timer or a 32-bit seconds clock.
// Notes on behaviour
// [R1] Two 16-bit halves exist; they can be joined as one 32-bit counter.
// [R2] In a 32-bit configuration the halves act only as one counter.
// [R3] Reset: control cleared, counts and loads 0xffff, prescales 0x00.
// [R4] Configuration 0 selects 32-bit timer, 1 selects 32-bit clock.
// [R5] A 32-bit load write splits: upper word to upper half load.
// [R6] A lower count read returns upper count above lower count.
// [R7] One-shot or periodic comes from the lower mode field only.
// [R8] Enabled timer counts down, reloads the joined load after zero.
// [R9] One-shot stops and clears its enable; periodic keeps going.
// [R10] Zero sets timeout raw flag until cleared; masked copy if enabled.
// [R11] Converter trigger pulses at timeout only if its enable is set.
// [R12] A load written while running is taken the next cycle.
// [R13] Stall bit plus debug halt freezes the count; it resumes after.
// [R14] Entering clock mode loads the counter with one; it counts up.
// [R15] Later clock mode values come only through the match register.
// [R16] The pin supplies 32.768 kHz, divided to one second ticks.
// [R17] At the match value the clock rolls to zero and keeps counting.
// [R18] Clock match sets raw flag, masked flag and interrupt if enabled.
// [R19] With the clock enable bit set, stall bits are ignored.
// [R20] Converter triggers of all timers are ORed into one trigger.
// [R21] Capture pins start as plain I/O; software routes them here.
// [R22] Interrupt is high while any masked flag is set.
//
// The register offsets and the strobed register port are this design's own decisions.
`default_nettype none
module gpt_timer
    import gpt_pkg::*;
#(
    parameter int TICK_DIV = CLOCK_DIV
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        debug_halt,
    input  wire logic        capture_compare_pwm_pin,
    input  wire logic        other_timer_trigger,
    output logic             adc_trigger,
    output logic             timer_irq
);
    logic [2:0]  width_config_register;
    logic [3:0]  lower_half_mode_register;
    logic [3:0]  upper_half_mode_register;
    logic [15:0] timer_control_register;
    logic [3:0]  interrupt_mask_register;
    logic [3:0]  raw_status_register;
    logic [15:0] lower_half_interval_load;
    logic [15:0] upper_half_interval_load;
    logic [15:0] lower_match;
    logic [15:0] upper_match;
    logic [7:0]  lower_half_prescale;
    logic [7:0]  upper_half_prescale;
    logic [31:0] count;
    logic        tick;
    logic        is_joined;
    logic        timer_mode;
    logic        clock_mode;
    logic        timer_run;
    logic        timeout_evt;
    logic        clock_run;
    logic        clock_step;
    logic        match_evt;
    logic        one_shot;
    logic        load_write;
    logic        enter_clock;
    logic [3:0]  masked_status;
    logic [3:0]  status_set;
    logic [31:0] joined_load;
    logic [31:0] joined_match;

    assign joined_load  = {upper_half_interval_load, lower_half_interval_load};
    assign joined_match = {upper_match, lower_match};

    // Mode decode; the upper mode register plays no part when joined.
    assign is_joined   = (width_config_register == CFG_TIMER32) ||
                         (width_config_register == CFG_CLOCK32); // [R2]
    assign timer_mode  = width_config_register == CFG_TIMER32; // [R4]
    assign clock_mode  = width_config_register == CFG_CLOCK32; // [R4]
    assign one_shot    = lower_half_mode_register[1:0] == MODE_ONE_SHOT; // [R7]
    assign load_write  = wr_en && (addr == OFS_LOWER_LOAD);
    assign enter_clock = wr_en && (addr == OFS_WIDTH_CFG) &&
                         (wr_data[2:0] == CFG_CLOCK32) && !clock_mode;

    // The stall only bites while the clock enable bit is clear.
    assign timer_run   = timer_mode && timer_control_register[CTL_LOWER_EN] &&
                         !(debug_halt &&
                           timer_control_register[CTL_LOWER_STALL] && // [R19]
                           !timer_control_register[CTL_CLOCK_EN]); // [R13]
    assign timeout_evt = timer_run && (count == 32'h0000_0000); // [R8]
    assign clock_run   = clock_mode && timer_control_register[CTL_LOWER_EN];
    assign clock_step  = clock_run && tick &&
                         !(debug_halt &&
                           (timer_control_register[CTL_LOWER_STALL] ||
                            timer_control_register[CTL_UPPER_STALL]) &&
                           !timer_control_register[CTL_CLOCK_EN]); // [R19]
    assign match_evt   = clock_step && (count == joined_match); // [R17]

    // The pin clock is divided to one second ticks in the helper.
    gpt_tick_div #(
        .DIV      (TICK_DIV)
    ) u_tick_div (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_clk  (capture_compare_pwm_pin),
        .run      (clock_run),
        .tick     (tick)
    ); // [R16]

    // Configuration and mode registers; all cleared at reset.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            width_config_register    <= 3'h0; // [R3]
            lower_half_mode_register <= 4'h0;
            upper_half_mode_register <= 4'h0;
            interrupt_mask_register  <= 4'h0;
            lower_half_prescale      <= RST_PRESCALE; // [R3]
            upper_half_prescale      <= RST_PRESCALE;
        end
        else if (wr_en)
        begin
            case (addr)
                OFS_WIDTH_CFG:   width_config_register    <= wr_data[2:0];
                OFS_LOWER_MODE:  lower_half_mode_register <= wr_data[3:0];
                OFS_UPPER_MODE:  upper_half_mode_register <= wr_data[3:0];
                OFS_IRQ_MASK:    interrupt_mask_register  <= wr_data[3:0];
                OFS_LOWER_PRESC: lower_half_prescale      <= wr_data[7:0];
                OFS_UPPER_PRESC: upper_half_prescale      <= wr_data[7:0];
                default:         ;
            endcase
        end
    end

    // Control register; a one-shot timeout clears the enable, and that
    // hardware clear takes priority over a software write in the same cycle.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_control_register <= 16'h0000; // [R3]
        end
        else if (timeout_evt && one_shot)
        begin
            timer_control_register <= ((wr_en && addr == OFS_CONTROL) ?
                wr_data[15:0] : timer_control_register) &
                ~(16'h0001 << CTL_LOWER_EN); // [R9]
        end
        else if (wr_en && addr == OFS_CONTROL)
        begin
            timer_control_register <= wr_data[15:0];
        end
    end

    // Load and match registers; joined writes split across both halves.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lower_half_interval_load <= RST_HALF_LOAD; // [R3]
            upper_half_interval_load <= RST_HALF_LOAD;
            lower_match              <= 16'hffff;
            upper_match              <= 16'hffff;
        end
        else if (wr_en)
        begin
            if (addr == OFS_LOWER_LOAD)
            begin
                lower_half_interval_load <= wr_data[15:0]; // [R5]
                if (is_joined)
                begin
                    upper_half_interval_load <= wr_data[31:16]; // [R5]
                end
            end
            else if (addr == OFS_UPPER_LOAD)
            begin
                upper_half_interval_load <= wr_data[15:0];
            end
            else if (addr == OFS_LOWER_MATCH)
            begin
                lower_match <= wr_data[15:0]; // [R15]
                if (is_joined)
                begin
                    upper_match <= wr_data[31:16];
                end
            end
            else if (addr == OFS_UPPER_MATCH)
            begin
                upper_match <= wr_data[15:0];
            end
        end
    end

    // The joined counter. Writes to the count registers are not accepted,
    // so in clock mode only the match register steers the value.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= {RST_HALF_COUNT, RST_HALF_COUNT}; // [R3]
        end
        else if (enter_clock)
        begin
            count <= CLOCK_FIRST; // [R14]
        end
        else if (load_write && timer_mode)
        begin
            count <= wr_data; // [R12]
        end
        else if (timeout_evt)
        begin
            count <= joined_load; // [R8]
        end
        else if (timer_run)
        begin
            count <= count - 32'h0000_0001; // [R1] [R8]
        end
        else if (match_evt)
        begin
            count <= 32'h0000_0000; // [R17]
        end
        else if (clock_step)
        begin
            count <= count + 32'h0000_0001; // [R14]
        end
    end

    // Status flags: a new event wins over a clear in the same cycle.
    assign status_set = (4'(timeout_evt) << ST_LOWER_TIMEOUT) |
                        (4'(match_evt) << ST_CLOCK_MATCH);
    assign masked_status = raw_status_register & interrupt_mask_register;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            raw_status_register <= 4'h0;
        end
        else if (wr_en && addr == OFS_STAT_CLEAR)
        begin
            raw_status_register <= (raw_status_register & ~wr_data[3:0]) |
                                   status_set; // [R10] [R18]
        end
        else
        begin
            raw_status_register <= raw_status_register | status_set; // [R10]
        end
    end

    // Interrupt and converter trigger outputs, both registered.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_irq   <= 1'b0;
            adc_trigger <= 1'b0;
        end
        else
        begin
            timer_irq   <= |masked_status; // [R18] [R22]
            adc_trigger <= (timeout_evt &&
                timer_control_register[CTL_LOWER_TRIG]) ||
                other_timer_trigger; // [R11] [R20]
        end
    end

    // Read port; the data stand in the cycle after the strobe only.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            case (addr)
                OFS_WIDTH_CFG:   rd_data <= {29'h0, width_config_register};
                OFS_LOWER_MODE:  rd_data <= {28'h0, lower_half_mode_register};
                OFS_UPPER_MODE:  rd_data <= {28'h0, upper_half_mode_register};
                OFS_CONTROL:     rd_data <= {16'h0, timer_control_register};
                OFS_IRQ_MASK:    rd_data <= {28'h0, interrupt_mask_register};
                OFS_RAW_STATUS:  rd_data <= {28'h0, raw_status_register};
                OFS_MASKED_STAT: rd_data <= {28'h0, masked_status};
                OFS_LOWER_LOAD:  rd_data <= is_joined ? joined_load :
                                     {16'h0, lower_half_interval_load};
                OFS_UPPER_LOAD:  rd_data <= {16'h0, upper_half_interval_load};
                OFS_LOWER_MATCH: rd_data <= is_joined ? joined_match :
                                     {16'h0, lower_match};
                OFS_UPPER_MATCH: rd_data <= {16'h0, upper_match};
                OFS_LOWER_PRESC: rd_data <= {24'h0, lower_half_prescale};
                OFS_UPPER_PRESC: rd_data <= {24'h0, upper_half_prescale};
                OFS_LOWER_COUNT: rd_data <= is_joined ? count :
                                     {16'h0, count[15:0]}; // [R6]
                OFS_UPPER_COUNT: rd_data <= {16'h0, count[31:16]};
                default:         rd_data <= 32'h0000_0000;
            endcase
        end
        else
        begin
            rd_data <= 32'h0000_0000;
        end
    end

    // Checks on the counting and flag behaviour.
    AST_RESET_COUNT: assert property (@(posedge core_clk) // [R3]
        $fell(rst) |-> (count == 32'hffff_ffff) &&
        (joined_load == 32'hffff_ffff) && (timer_control_register == 16'h0))
        else $error("count or load not at reset value");

    AST_RELOAD_AT_ZERO: assert property (@(posedge core_clk) // [R8]
        disable iff (rst)
        timeout_evt && !wr_en |=> count == $past(joined_load))
        else $error("zero did not reload the joined load");

    AST_ONE_SHOT_STOP: assert property (@(posedge core_clk) // [R9]
        disable iff (rst)
        timeout_evt && one_shot |=> !timer_control_register[CTL_LOWER_EN]
        ##1 ($stable(count) || $past(wr_en)))
        else $error("one-shot kept counting");

    AST_TIMEOUT_FLAG: assert property (@(posedge core_clk) // [R10]
        disable iff (rst)
        timeout_evt |=> raw_status_register[ST_LOWER_TIMEOUT])
        else $error("timeout flag not set");

    AST_TRIGGER_GATE: assert property (@(posedge core_clk) // [R11]
        disable iff (rst)
        adc_trigger && !$past(other_timer_trigger) |->
        $past(timeout_evt) && $past(timer_control_register[CTL_LOWER_TRIG]))
        else $error("trigger without enabled timeout");

    AST_LOAD_TAKEN: assert property (@(posedge core_clk) // [R12]
        disable iff (rst)
        load_write && timer_mode && !enter_clock |=> count == $past(wr_data))
        else $error("new load not taken next cycle");

    AST_STALL_FREEZE: assert property (@(posedge core_clk) // [R13]
        disable iff (rst)
        timer_mode && debug_halt && timer_control_register[CTL_LOWER_STALL] &&
        !timer_control_register[CTL_CLOCK_EN] && !wr_en |=> $stable(count))
        else $error("count moved during stall");

    AST_CLOCK_FIRST: assert property (@(posedge core_clk) // [R14]
        disable iff (rst)
        enter_clock |=> count == 32'h0000_0001)
        else $error("clock mode did not start at one");

    AST_CLOCK_ROLL: assert property (@(posedge core_clk) // [R17]
        disable iff (rst)
        match_evt && !wr_en |=> count == 32'h0000_0000 &&
        raw_status_register[ST_CLOCK_MATCH])
        else $error("match did not roll over and flag");

    AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) // [R22]
        disable iff (rst)
        ##1 timer_irq == $past(|masked_status))
        else $error("interrupt does not follow masked flags");
endmodule : gpt_timer
`default_nettype wire

/* verification/gp_timer_32bit_modes_tb.sv */
// Self-checking bench for the joined 32-bit timer and seconds clock.
`default_nettype none
module gp_timer_32bit_modes_tb
    import gpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        debug_halt;
    logic        pin_clk;
    logic        pin_run;
    logic        other_trig;
    logic        adc_trigger;
    logic        timer_irq;
    int          error_cnt;
    int          checks_done;

    // A short divider keeps a seconds tick within a few thousand cycles.
    gpt_timer #(.TICK_DIV(4)) dut_u (
        .core_clk                (core_clk),
        .rst                     (rst),
        .addr                    (addr),
        .wr_data                 (wr_data),
        .wr_en                   (wr_en),
        .rd_en                   (rd_en),
        .rd_data                 (rd_data),
        .debug_halt              (debug_halt),
        .capture_compare_pwm_pin (pin_clk),
        .other_timer_trigger     (other_trig),
        .adc_trigger             (adc_trigger),
        .timer_irq               (timer_irq)
    );

    gpt_pin_clock_model pin_u (
        .run     (pin_run),
        .pin_clk (pin_clk)
    );

    // The 10 MHz core clock.
    always #50 core_clk = ~core_clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask : wr

    // Read data is registered, so it is taken just after the next edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic chk_rd(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask : chk_rd

    // Bounded wait on the trigger (irq=0) or the interrupt (irq=1).
    task automatic wait_for(input bit irq, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge core_clk);
            #1;
            if ((irq ? timer_irq : adc_trigger) === lvl)
                return;
        end
        chk("bounded wait", 32'h1, 32'h0);
        end_sim();
    endtask : wait_for

    task automatic t_reset();
        chk_rd("joined count", OFS_LOWER_COUNT, 32'hffff_ffff);
        chk_rd("upper load", OFS_UPPER_LOAD, {16'h0, RST_HALF_LOAD});
        chk_rd("prescale", OFS_UPPER_PRESC, {24'h0, RST_PRESCALE});
        chk_rd("control", OFS_CONTROL, 32'h0);
        chk_rd("unmapped", 8'h44, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_one_shot();
        wr(OFS_LOWER_LOAD, 32'habcd_0005);
        chk_rd("split load", OFS_UPPER_LOAD, 32'h0000_abcd);
        chk_rd("joined count", OFS_LOWER_COUNT, 32'habcd_0005);
        chk_rd("upper count", OFS_UPPER_COUNT, 32'h0000_abcd);
        wr(OFS_LOWER_LOAD, 32'h5);
        // The upper mode asks for periodic and must be overruled.
        wr(OFS_UPPER_MODE, {30'h0, MODE_PERIODIC});
        wr(OFS_LOWER_MODE, {30'h0, MODE_ONE_SHOT});
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CONTROL, 32'h21);
        wait_for(1'b0, 1'b1, 20);
        wait_for(1'b1, 1'b1, 3);
        chk_rd("enable cleared", OFS_CONTROL, 32'h20);
        chk_rd("stopped reload", OFS_LOWER_COUNT, 32'h5);
        chk_rd("raw status", OFS_RAW_STATUS, 32'h1);
        chk_rd("masked status", OFS_MASKED_STAT, 32'h1);
        wr(OFS_STAT_CLEAR, 32'h1);
        wait_for(1'b1, 1'b0, 4);
        chk_rd("raw cleared", OFS_RAW_STATUS, 32'h0);
        $display("test one-shot done");
    endtask : t_one_shot

    task automatic t_periodic();
        int          hits;
        logic [31:0] d;
        hits = 0;
        wr(OFS_LOWER_MODE, {30'h0, MODE_PERIODIC});
        wr(OFS_LOWER_LOAD, 32'h3);
        wr(OFS_CONTROL, 32'h1);
        repeat (20)
        begin
            @(posedge core_clk);
            #1;
            if (adc_trigger === 1'b1)
                hits++;
        end
        chk("gated trigger", 32'h0, hits);
        chk_rd("periodic raw", OFS_RAW_STATUS, 32'h1);
        chk_rd("still enabled", OFS_CONTROL, 32'h1);
        wr(OFS_LOWER_LOAD, 32'h200);
        wr(OFS_LOWER_LOAD, 32'h40);
        rd(OFS_LOWER_COUNT, d);
        chk("live reload", 32'h1,
            {31'h0, d <= 32'h40 && d >= 32'h3c});
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_STAT_CLEAR, 32'h1);
        // Another timer's trigger must pass through the shared output; the
        // registered pulse stands only in the cycle after the input pulse.
        @(posedge core_clk);
        other_trig <= 1'b1;
        @(posedge core_clk);
        other_trig <= 1'b0;
        #1;
        chk("shared trigger", 32'h1, {31'h0, adc_trigger});
        $display("test periodic done");
    endtask : t_periodic

    task automatic t_stall();
        logic [31:0] d;
        @(posedge core_clk);
        debug_halt <= 1'b1;
        wr(OFS_LOWER_LOAD, 32'h100);
        wr(OFS_CONTROL, 32'h3);
        repeat (5) @(posedge core_clk);
        chk_rd("frozen count", OFS_LOWER_COUNT, 32'h100);
        @(posedge core_clk);
        debug_halt <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(OFS_LOWER_COUNT, d);
        chk("resumed", 32'h1, {31'h0, d < 32'h100 && d > 32'he0});
        wr(OFS_CONTROL, 32'h0);
        $display("test stall done");
    endtask : t_stall

    task automatic t_clock();
        time t0;
        time el;
        wr(OFS_WIDTH_CFG, {29'h0, CFG_CLOCK32});
        chk_rd("clock start", OFS_LOWER_COUNT, CLOCK_FIRST);
        wr(OFS_LOWER_LOAD, 32'h77);
        chk_rd("load ignored", OFS_LOWER_COUNT, CLOCK_FIRST);
        wr(OFS_LOWER_MATCH, 32'h2);
        wr(OFS_IRQ_MASK, 32'h8);
        // A debug halt with the stall bit set must not hold the clock.
        @(posedge core_clk);
        debug_halt <= 1'b1;
        wr(OFS_CONTROL, 32'h13);
        t0 = $time;
        wait_for(1'b1, 1'b1, 4000);
        el = $time - t0;
        chk("two ticks", 32'h1, {31'h0, el > 210000 && el < 250000});
        chk_rd("rolled over", OFS_LOWER_COUNT, 32'h0);
        chk_rd("match raw", OFS_RAW_STATUS, 32'h8);
        chk_rd("match masked", OFS_MASKED_STAT, 32'h8);
        wr(OFS_STAT_CLEAR, 32'h8);
        wait_for(1'b1, 1'b0, 4);
        chk_rd("match cleared", OFS_MASKED_STAT, 32'h0);
        $display("test clock done");
    endtask : t_clock

    // Reset for 20 cycles, then run every scenario in turn.
    initial
    begin
        core_clk    = 1'b0;
        rst         = 1'b1;
        addr        = 8'h00;
        wr_data     = 32'h0;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        debug_halt  = 1'b0;
        other_trig  = 1'b0;
        pin_run     = 1'b1;
        error_cnt   = 0;
        checks_done = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_one_shot();
        t_periodic();
        t_stall();
        t_clock();
        end_sim();
    end
endmodule : gp_timer_32bit_modes_tb
`default_nettype wire

/* verification/gpt_pin_clock_model.sv */
// Model of the external seconds crystal that feeds the capture pin.
`default_nettype none
module gpt_pin_clock_model
(
    input  wire logic run,
    output logic      pin_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // Half of one 32.768 kHz period, rounded to a whole nanosecond.
    localparam int HALF_NS = 15259;

    // The source only toggles once the pin is routed and running; it rests
    // low otherwise so no stray edge reaches the divider.
    initial
    begin
        pin_clk = 1'b0;
        forever
        begin
            #(HALF_NS);
            if (run)
                pin_clk = ~pin_clk;
            else
                pin_clk = 1'b0;
        end
    end
endmodule : gpt_pin_clock_model
`default_nettype wire
